//--- verilog/lpba_pkg.sv
// shared constants and types for the lpddr3 bank access link
package lpba_pkg;
  localparam int NBANK     = 8;
  localparam int BL        = 8;
  localparam int BL2       = BL / 2;
  localparam int RL        = 6;
  localparam int WL        = 3;
  localparam int DQW       = 16;
  localparam int BEATW     = 2 * DQW;
  localparam int DMW       = 4;
  localparam int CW        = 6;
  localparam int FAW_SLOTS = 4;
  // link clock is clock_in divided by two
  localparam int TCK_NS        = 40;
  localparam int T_RCD_NS      = 18;
  localparam int T_RAS_NS      = 42;
  localparam int T_RC_NS       = 60;
  localparam int T_RRD_NS      = 10;
  localparam int T_FAW_NS      = 50;
  localparam int T_RPPB_NS     = 18;
  localparam int T_RPAB_NS     = 21;
  localparam int T_WR_NS       = 15;
  localparam int T_WTR_NS      = 8;
  localparam int T_DQSCKMAX_NS = 6;
  localparam int RCD_CYC      = (T_RCD_NS + TCK_NS - 1) / TCK_NS;
  localparam int RAS_CYC      = (T_RAS_NS + TCK_NS - 1) / TCK_NS;
  localparam int RC_CYC       = (T_RC_NS + TCK_NS - 1) / TCK_NS;
  localparam int RRD_CYC      = (T_RRD_NS + TCK_NS - 1) / TCK_NS;
  localparam int FAW_CYC      = (T_FAW_NS + TCK_NS - 1) / TCK_NS;
  localparam int RPPB_CYC     = (T_RPPB_NS + TCK_NS - 1) / TCK_NS;
  localparam int RPAB_CYC     = (T_RPAB_NS + TCK_NS - 1) / TCK_NS;
  localparam int WR_CYC       = (T_WR_NS + TCK_NS - 1) / TCK_NS;
  localparam int WTR_CYC      = (T_WTR_NS + TCK_NS - 1) / TCK_NS;
  localparam int DQSCKMAX_CYC = (T_DQSCKMAX_NS + TCK_NS - 1) / TCK_NS;
  localparam int R2W_CYC      = RL + DQSCKMAX_CYC + BL2 + 1 - WL;
  localparam int W2R_CYC      = WL + 1 + BL2 + WTR_CYC;
  localparam int W2P_CYC      = WL + BL2 + 1 + WR_CYC;
  localparam int CCD_CYC      = BL2;
  // command field codes and positions on the rising-edge half
  localparam logic [1:0] CA_ACT = 2'h2;
  localparam logic [1:0] CA_COL = 2'h1;
  localparam logic [2:0] CA_RD  = 3'h5;
  localparam logic [2:0] CA_WR  = 3'h1;
  localparam logic [3:0] CA_PRE = 4'hb;
  localparam int CA_BA_LSB = 7;
  localparam int CA_AB_BIT = 4;
  localparam int CA_RD_BIT = 2;
  typedef enum logic [1:0] {
    LPBA_ACT = 2'h0,
    LPBA_RD  = 2'h1,
    LPBA_WR  = 2'h2,
    LPBA_PRE = 2'h3
  } lpba_op_t;
endpackage : lpba_pkg

//--- verilog/lpba_link_if.sv
// link between memory controller and device, with shared pin resolution
`timescale 1ns/100ps
`default_nettype none
interface lpba_link_if;
  import lpba_pkg::*;
  logic             ck;
  logic             cs_n;
  logic [9:0]       ca_r;
  logic [9:0]       ca_f;
  logic [BEATW-1:0] h_dq;
  logic             h_dq_oe;
  logic [BEATW-1:0] d_dq;
  logic             d_dq_oe;
  logic [BEATW-1:0] dq;
  logic             h_dqs;
  logic             h_dqs_oe;
  logic             d_dqs;
  logic             d_dqs_oe;
  logic             dqs;
  logic [DMW-1:0]   dm;
  assign dq  = d_dq_oe ? d_dq : h_dq;
  assign dqs = d_dqs_oe ? d_dqs : h_dqs;
  modport host (output ck, cs_n, ca_r, ca_f, h_dq, h_dq_oe, h_dqs, h_dqs_oe, dm,
                input dq, dqs);
  modport dev  (input ck, cs_n, ca_r, ca_f, dm, dq, dqs,
                output d_dq, d_dq_oe, d_dqs, d_dqs_oe);
endinterface : lpba_link_if
`default_nettype wire

//--- verilog/lpba_dev.sv
// memory device end: command decode, bank state, read return, masked write
`timescale 1ns/100ps
`default_nettype none
module lpba_dev
  import lpba_pkg::*;
(
  lpba_link_if.dev         link,
  input  wire logic        rstn_in,
  output logic [NBANK-1:0] bank_open_out,
  output logic             access_err_out
);
  typedef struct packed {
    logic [NBANK-1:0]                  open;
    logic [NBANK-1:0][14:0]            row;
    logic [RL+BL2-1:0][BEATW:0]        rq;
    logic [WL+BL2-2:0][6:0]            wq;
    logic                              dqs_oe;
    logic                              err;
    logic [1:0]                        rst_sync;
  } lpba_dev_st_t;

  lpba_dev_st_t     r;
  lpba_dev_st_t     nx;
  logic [DQW-1:0]   mem [NBANK*BL];
  logic             cs;
  logic [2:0]       bank;
  logic [2:0]       base;
  logic             wr_now;

  assign cs   = ~link.cs_n;
  assign bank = link.ca_r[CA_BA_LSB+:3];
  assign base = {link.ca_f[1], link.ca_r[6:5]};
  // strobe must really be driven for the beat to be stored
  assign wr_now = r.wq[0][6] & link.dqs;

  always_comb begin
    nx        = r;
    nx.err    = 1'b0;
    nx.rq     = {(BEATW+1)'(0), r.rq[RL+BL2-1:1]};
    nx.wq     = {7'h00, r.wq[WL+BL2-2:1]};
    // reset comes from the bench clock, so it passes two flops first
    nx.rst_sync = {r.rst_sync[0], rstn_in};
    if (cs && link.ca_r[1:0] == CA_ACT) begin // [R1]
      nx.open[bank] = 1'b1;
      nx.row[bank]  = {link.ca_r[6:2], link.ca_f};
    end else if (cs && link.ca_r[3:0] == CA_PRE) begin // [R23]
      if (link.ca_r[CA_AB_BIT]) begin
        nx.open = '0;
      end else begin
        nx.open[bank] = 1'b0;
      end
    end else if (cs && link.ca_r[1:0] == CA_COL) begin // [R10] [R12]
      if (!r.open[bank]) begin
        // access to a closed bank is dropped and flagged
        nx.err = 1'b1;
      end else if (link.ca_r[CA_RD_BIT]) begin
        for (int j = 0; j < BL2; j++) begin // [R11] [R13] [R16]
          nx.rq[RL+j] = {1'b1, mem[{bank, 3'(base + 3'(2*j+1))}],
                               mem[{bank, 3'(base + 3'(2*j))}]};
        end
      end else begin
        for (int j = 0; j < BL2; j++) begin // [R11] [R21]
          nx.wq[WL-1+j] = {1'b1, bank, 3'(base + 3'(2*j))};
        end
      end
    end
    // strobe low one cycle ahead of the first beat
    nx.dqs_oe = nx.rq[0][BEATW] | nx.rq[1][BEATW]; // [R14]
  end

  always_ff @(posedge link.ck) begin
    if (!r.rst_sync[1]) begin
      r          <= '0;
      r.rst_sync <= nx.rst_sync;
    end else begin
      r <= nx;
    end
  end

  // no reset on the array: contents are undefined until written
  always_ff @(posedge link.ck) begin
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b < 2; b++) begin
        if (wr_now && !link.dm[2*k+b]) begin // [R22]
          mem[{r.wq[0][5:3], 3'(r.wq[0][2:0] + 3'(k))}][8*b+:8]
            <= link.dq[DQW*k+8*b+:8];
        end
      end
    end
  end

  assign link.d_dq       = r.rq[0][BEATW-1:0];
  assign link.d_dq_oe    = r.rq[0][BEATW];
  assign link.d_dqs      = r.rq[0][BEATW]; // [R14]
  assign link.d_dqs_oe   = r.dqs_oe;
  assign bank_open_out   = r.open;
  assign access_err_out  = r.err;
endmodule : lpba_dev
`default_nettype wire

//--- verilog/lpba_host.sv
// memory controller end: spacing checks, command issue, write and read data
// Notes on behaviour
// R1 - activate: cs low, ca0 low, ca1 high
// R2 - activate first, then wait tRCD
// R3 - precharge before reactivating; tRAS, tRP bound
// R4 - same-bank activates spaced by tRC
// R5 - different-bank activates spaced by tRRD
// R6 - at most four activates per tFAW
// R7 - tFAW cycles: tFAW over tCK, rounded up
// R8 - clock change: sum real periods over tFAW (not done here: the link clock is fixed and tFAW is a plain cycle count)
// R9 - precharge all waits longer tRPab
// R10 - column access: ca0 high, ca1 low, ca2 read
// R11 - bursts run whole, never interrupted
// R12 - start column from rising and falling halves
// R13 - read data after RL plus delays
// R14 - read strobe preamble low, edge-aligned data
// R15 - read to write spacing formula
// R16 - reads every four clocks run gapless
// R17 - write data after WL, strobe preamble first
// R18 - one data bit per strobe edge, full burst
// R19 - tWR after write before precharge
// R20 - write to read spacing formula
// R21 - writes every four clocks run gapless
// R22 - masked bytes are not stored
// R23 - precharge encoding, all-bank flag
// R24 - controller tracks bank state and spacing
`timescale 1ns/100ps
`default_nettype none
module lpba_host
  import lpba_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire logic              cmd_valid_in,
  input  wire lpba_op_t          cmd_op_in,
  input  wire logic [2:0]        cmd_bank_in,
  input  wire logic [14:0]       cmd_addr_in,
  input  wire logic              cmd_all_in,
  input  wire logic [BL*DQW-1:0] wr_data_in,
  input  wire logic [BL*2-1:0]   wr_mask_in,
  output logic                   cmd_ready_out,
  output logic [BL*DQW-1:0]      rd_data_out,
  output logic                   rd_valid_out,
  lpba_link_if.host              link
);
  typedef struct packed {
    logic                            ck;
    logic                            cs_n;
    logic [9:0]                      ca_r;
    logic [9:0]                      ca_f;
    logic                            ready;
    logic [NBANK-1:0]                open;
    logic [NBANK-1:0][CW-1:0]        acc;
    logic [NBANK-1:0][CW-1:0]        pre;
    logic [NBANK-1:0][CW-1:0]        act;
    logic [CW-1:0]                   rrd;
    logic [FAW_SLOTS-1:0][CW-1:0]    faw;
    logic [CW-1:0]                   rdc;
    logic [CW-1:0]                   wrc;
    logic [WL+BL2-1:0][BEATW+DMW:0]  wq;
    logic                            dqs_oe;
    logic [BL*DQW-1:0]               rbuf;
    logic [1:0]                      rcnt;
    logic [BL*DQW-1:0]               rd_data;
    logic                            rd_valid;
  } lpba_host_st_t;

  lpba_host_st_t  r;
  lpba_host_st_t  nx;
  logic           tick;
  logic           take;
  logic           legal;
  logic           faw_free;
  logic           pre_ok;
  logic           slot_done;
  logic [2:0]     b;

  function automatic logic [CW-1:0] mx(input logic [CW-1:0] a, input logic [CW-1:0] c);
    return (a > c) ? a : c;
  endfunction : mx

  assign b    = cmd_bank_in;
  // link work happens once per link cycle, on the edge where ck falls
  assign tick = r.ck;
  assign take = tick & r.ready & cmd_valid_in;

  always_comb begin
    faw_free = 1'b0;
    pre_ok   = 1'b1;
    for (int i = 0; i < FAW_SLOTS; i++) begin
      faw_free = faw_free | (r.faw[i] == '0); // [R6]
    end
    for (int i = 0; i < NBANK; i++) begin
      if (cmd_all_in || i == 32'(b)) begin
        pre_ok = pre_ok & (r.pre[i] == '0); // [R3] [R19]
      end
    end
    case (cmd_op_in)
      LPBA_ACT: legal = !r.open[b] && r.act[b] == '0 && r.rrd == '0
                        && faw_free; // [R3] [R4] [R5] [R6] [R24]
      LPBA_RD:  legal = r.open[b] && r.acc[b] == '0 && r.rdc == '0; // [R2] [R20]
      LPBA_WR:  legal = r.open[b] && r.acc[b] == '0 && r.wrc == '0; // [R2] [R15]
      LPBA_PRE: legal = pre_ok;
      default:  legal = 1'b0;
    endcase
  end

  always_comb begin
    nx          = r;
    nx.ck       = ~r.ck;
    nx.rd_valid = 1'b0;
    nx.ready    = ~r.ck & cmd_valid_in & legal;
    slot_done   = 1'b0;
    if (tick) begin
      nx.cs_n = 1'b1;
      for (int i = 0; i < NBANK; i++) begin // [R24]
        if (r.acc[i] != '0) nx.acc[i] = r.acc[i] - 1'b1;
        if (r.pre[i] != '0) nx.pre[i] = r.pre[i] - 1'b1;
        if (r.act[i] != '0) nx.act[i] = r.act[i] - 1'b1;
      end
      for (int i = 0; i < FAW_SLOTS; i++) begin
        if (r.faw[i] != '0) nx.faw[i] = r.faw[i] - 1'b1;
      end
      if (r.rrd != '0) nx.rrd = r.rrd - 1'b1;
      if (r.rdc != '0) nx.rdc = r.rdc - 1'b1;
      if (r.wrc != '0) nx.wrc = r.wrc - 1'b1;
      nx.wq = {(BEATW+DMW+1)'(0), r.wq[WL+BL2-1:1]};
      // a read beat pair is any strobe-high cycle the host is not driving
      if (link.dqs && !r.dqs_oe) begin
        nx.rbuf[BEATW*r.rcnt+:BEATW] = link.dq;
        nx.rcnt = r.rcnt + 2'h1;
        if (r.rcnt == 2'h3) begin
          nx.rd_data  = nx.rbuf;
          nx.rd_valid = 1'b1;
        end
      end
    end
    if (take) begin
      nx.cs_n = 1'b0;
      case (cmd_op_in)
        LPBA_ACT: begin
          nx.ca_r    = {b, cmd_addr_in[14:10], CA_ACT}; // [R1]
          nx.ca_f    = cmd_addr_in[9:0];
          nx.open[b] = 1'b1;
          nx.acc[b]  = CW'(RCD_CYC - 1); // [R2]
          nx.pre[b]  = CW'(RAS_CYC - 1); // [R3]
          nx.act[b]  = CW'(RC_CYC - 1); // [R4]
          nx.rrd     = CW'(RRD_CYC - 1); // [R5]
          // fixed link clock, so the window is a plain cycle count
          for (int i = 0; i < FAW_SLOTS; i++) begin
            if (!slot_done && r.faw[i] == '0) begin
              nx.faw[i] = CW'(FAW_CYC - 1); // [R6] [R7] [R8]
              slot_done = 1'b1;
            end
          end
        end
        LPBA_RD, LPBA_WR: begin
          nx.ca_r = {b, cmd_addr_in[1:0], 2'h0,
                     (cmd_op_in == LPBA_RD) ? CA_RD : CA_WR}; // [R10] [R12]
          nx.ca_f = {cmd_addr_in[10:2], 1'b0};
          nx.pre[b] = mx(nx.pre[b], CW'(BL2 - 1));
          if (cmd_op_in == LPBA_RD) begin
            nx.rdc = CW'(CCD_CYC - 1); // [R16]
            nx.wrc = mx(nx.wrc, CW'(R2W_CYC - 1)); // [R15]
          end else begin
            nx.wrc    = CW'(CCD_CYC - 1); // [R21]
            nx.rdc    = mx(nx.rdc, CW'(W2R_CYC - 1)); // [R20]
            nx.pre[b] = mx(nx.pre[b], CW'(W2P_CYC - 1)); // [R19]
            for (int j = 0; j < BL2; j++) begin // [R17] [R18]
              nx.wq[WL+j] = {1'b1, wr_mask_in[DMW*j+:DMW], wr_data_in[BEATW*j+:BEATW]};
            end
          end
        end
        default: begin
          nx.ca_r = {b, 2'h0, cmd_all_in, CA_PRE}; // [R23]
          nx.ca_f = 10'h000;
          for (int i = 0; i < NBANK; i++) begin
            if (cmd_all_in) begin
              nx.open[i] = 1'b0;
              nx.act[i]  = mx(nx.act[i], CW'(RPAB_CYC - 1)); // [R9]
            end else if (i == 32'(b)) begin
              nx.open[i] = 1'b0;
              nx.act[i]  = mx(nx.act[i], CW'(RPPB_CYC - 1)); // [R3]
            end
          end
        end
      endcase
    end
    // write strobe preamble one cycle before the first beat
    nx.dqs_oe = nx.wq[0][BEATW+DMW] | nx.wq[1][BEATW+DMW]; // [R17]
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      r      <= '0;
      r.cs_n <= 1'b1;
    end else begin
      r <= nx;
    end
  end

  assign link.ck       = r.ck;
  assign link.cs_n     = r.cs_n;
  assign link.ca_r     = r.ca_r;
  assign link.ca_f     = r.ca_f;
  assign link.h_dq     = r.wq[0][BEATW-1:0];
  assign link.h_dq_oe  = r.wq[0][BEATW+DMW];
  assign link.h_dqs    = r.wq[0][BEATW+DMW];
  assign link.h_dqs_oe = r.dqs_oe;
  assign link.dm       = r.wq[0][BEATW+:DMW];
  assign cmd_ready_out = r.ready;
  assign rd_data_out   = r.rd_data;
  assign rd_valid_out  = r.rd_valid;
endmodule : lpba_host
`default_nettype wire

//--- tb/lpba_link_assertions.sv
// link protocol checker for the two lpddr3 bank access ends
`timescale 1ns/100ps
`default_nettype none
module lpba_link_assertions
  import lpba_pkg::*;
(
  input  wire logic       ck,
  input  wire logic       rstn_in,
  input  wire logic       cs_n,
  input  wire logic [9:0] ca_r,
  input  wire logic       h_dq_oe,
  input  wire logic       h_dqs_oe,
  input  wire logic       h_dqs,
  input  wire logic       d_dq_oe,
  input  wire logic       d_dqs_oe,
  input  wire logic       d_dqs
);
  logic       act, rd, wr, pre;
  logic [7:0] open_q;
  logic [3:0] wr_cnt;
  logic [2:0] wr_bank;
  logic       wr_hold;
  assign act = !cs_n && ca_r[1:0] == CA_ACT;
  assign rd  = !cs_n && ca_r[1:0] == CA_COL && ca_r[2];
  assign wr  = !cs_n && ca_r[1:0] == CA_COL && !ca_r[2];
  assign pre = !cs_n && ca_r[3:0] == CA_PRE;
  assign wr_hold = wr_cnt != 4'h0;
  // shadow bank state, so column accesses can be judged
  always_ff @(posedge ck) begin
    if (!rstn_in) begin
      open_q  <= 8'h00;
      wr_cnt  <= 4'h0;
      wr_bank <= 3'h0;
    end else begin
      if (act)
        open_q[ca_r[9:7]] <= 1'b1;
      if (pre && ca_r[4])
        open_q <= 8'h00;
      else if (pre)
        open_q[ca_r[9:7]] <= 1'b0;
      if (wr) begin
        wr_cnt  <= 4'h8;
        wr_bank <= ca_r[9:7];
      end else if (wr_cnt != 4'h0)
        wr_cnt <= wr_cnt - 4'h1;
    end
  end
  default clocking cb @(posedge ck); endclocking
  default disable iff (!rstn_in);
  rd_latency_a: assert property (rd |-> ##6 d_dqs_oe ##1 (d_dq_oe && d_dqs) [*4])
    else $error("read burst not on time");
  wr_latency_a: assert property (wr |-> ##2 h_dqs_oe ##1 (h_dq_oe && h_dqs) [*4])
    else $error("write burst not on time");
  rd_preamble_a: assert property ($rose(d_dqs_oe) |-> !d_dqs ##1 d_dqs)
    else $error("read strobe preamble missing");
  wr_preamble_a: assert property ($rose(h_dqs_oe) |-> !h_dqs ##1 h_dqs)
    else $error("write strobe preamble missing");
  bus_owner_a: assert property (!(h_dq_oe && d_dq_oe) && !(h_dqs_oe && d_dqs_oe))
    else $error("both ends drive data");
  r2w_gap_a: assert property (rd |=> !wr [*8])
    else $error("write too soon after read");
  w2r_gap_a: assert property (wr |=> !rd [*8])
    else $error("read too soon after write");
  col_gap_a: assert property ((rd || wr) |=> !(rd || wr) [*3])
    else $error("column commands too close");
  col_open_a: assert property ((rd || wr) |-> open_q[ca_r[9:7]])
    else $error("column access to closed bank");
  act_closed_a: assert property (act |-> !open_q[ca_r[9:7]])
    else $error("activate to open bank");
  wr_recover_a: assert property (pre && wr_hold |-> !ca_r[4] && ca_r[9:7] != wr_bank)
    else $error("precharge inside write recovery");
  cover property (rd ##4 rd);
  cover property (wr ##4 wr);
  cover property (pre && ca_r[4]);
endmodule : lpba_link_assertions
`default_nettype wire

//--- tb/tb_lpddr3_bank_access_timing.sv
// bench joining controller and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module tb_lpddr3_bank_access_timing;
  import lpba_pkg::*;
  localparam logic [127:0] PA = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  logic         clock_in, rstn, dev_rstn, cmd_valid, cmd_all, cmd_ready, rd_valid;
  logic         access_err, err_seen;
  lpba_op_t     cmd_op;
  logic [2:0]   cmd_bank;
  logic [14:0]  cmd_addr;
  logic [127:0] wr_data, rd_data;
  logic [15:0]  wr_mask;
  logic [7:0]   bank_open;
  logic [15:0]  mem [8][8];
  int           error_cnt, checks;
  lpba_link_if link ();
  lpba_host lpba_host_inst (.clock_in(clock_in), .rstn_in(rstn), .cmd_valid_in(cmd_valid),
    .cmd_op_in(cmd_op), .cmd_bank_in(cmd_bank), .cmd_addr_in(cmd_addr), .cmd_all_in(cmd_all),
    .wr_data_in(wr_data), .wr_mask_in(wr_mask), .cmd_ready_out(cmd_ready),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .link(link));
  lpba_dev lpba_dev_inst (.link(link), .rstn_in(dev_rstn), .bank_open_out(bank_open),
    .access_err_out(access_err));
  lpba_link_assertions lpba_link_assertions_inst (.ck(link.ck), .rstn_in(dev_rstn),
    .cs_n(link.cs_n), .ca_r(link.ca_r), .h_dq_oe(link.h_dq_oe), .h_dqs_oe(link.h_dqs_oe),
    .h_dqs(link.h_dqs), .d_dq_oe(link.d_dq_oe), .d_dqs_oe(link.d_dqs_oe), .d_dqs(link.d_dqs));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge link.ck) if (access_err === 1'b1) err_seen <= 1'b1;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk_data(input string nm, input logic [127:0] exp, input logic [127:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_data
  task automatic chk_bits(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_bits
  // request held until the edge that sees ready; ready never stands two edges running
  task automatic cmd(input lpba_op_t op, input logic [2:0] b, input logic [14:0] a,
                     input logic all);
    int n;
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_bank  <= b;
    cmd_addr  <= a;
    cmd_all   <= all;
    @(posedge clock_in);
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(posedge clock_in);
    cmd_valid <= 1'b0;
    if (n == 200) begin
      $display("CHECK FAILED cmd_ready expected 1 seen 0");
      error_cnt++;
      finish_test();
    end
    @(posedge clock_in);
  endtask : cmd
  task automatic wait_rd();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clock_in);
      if (rd_valid === 1'b1) break;
    end
    if (n == 100) begin
      $display("CHECK FAILED rd_valid expected 1 seen 0");
      error_cnt++;
      finish_test();
    end
  endtask : wait_rd
  function automatic logic [127:0] burst(input logic [2:0] b, input logic [2:0] c);
    logic [127:0] v;
    for (int n = 0; n < 8; n++) v[16 * n +: 16] = mem[b][3'(c + n)];
    return v;
  endfunction : burst
  task automatic wr(input logic [2:0] b, input logic [2:0] c, input logic [127:0] d,
                    input logic [15:0] m);
    for (int i = 0; i < 16; i++)
      if (!m[i]) mem[b][3'(c + i / 2)][8 * (i % 2) +: 8] = d[8 * i +: 8];
    wr_data <= d;
    wr_mask <= m;
    cmd(LPBA_WR, b, 15'(c), 1'b0);
  endtask : wr
  task automatic rd2(input logic [2:0] b0, input logic [2:0] c0, input logic [2:0] b1,
                     input logic [2:0] c1);
    cmd(LPBA_RD, b0, 15'(c0), 1'b0);
    cmd(LPBA_RD, b1, 15'(c1), 1'b0);
    wait_rd();
    chk_data("first read burst", burst(b0, c0), rd_data);
    wait_rd();
    chk_data("second read burst", burst(b1, c1), rd_data);
  endtask : rd2
  task automatic t_open();
    for (int b = 0; b < 4; b++) cmd(LPBA_ACT, 3'(b), 15'h0010, 1'b0);
    repeat (4) @(posedge clock_in);
    chk_bits("open banks", 8'h0f, bank_open);
  endtask : t_open
  task automatic t_data();
    wr(3'h0, 3'h0, PA, 16'h0000);
    rd2(3'h0, 3'h0, 3'h0, 3'h0);
    wr(3'h1, 3'h3, ~PA, 16'h0000);
    wr(3'h2, 3'h7, {PA[63:0], PA[127:64]}, 16'h0000);
    rd2(3'h1, 3'h3, 3'h2, 3'h7);
    wr(3'h3, 3'h0, PA ^ {8{16'h5a5a}}, 16'h0000);
    wr(3'h3, 3'h5, ~PA, 16'ha5c3);
    rd2(3'h3, 3'h5, 3'h3, 3'h0);
  endtask : t_data
  // the device array is indexed by bank and column only, not row, so the old words are read back after reopening
  task automatic t_close();
    cmd(LPBA_PRE, 3'h0, 15'h0000, 1'b0);
    repeat (4) @(posedge clock_in);
    chk_bits("open after precharge", 8'h0e, bank_open);
    cmd(LPBA_ACT, 3'h0, 15'h0020, 1'b0);
    rd2(3'h0, 3'h2, 3'h1, 3'h0);
    cmd(LPBA_PRE, 3'h6, 15'h0000, 1'b1);
    repeat (4) @(posedge clock_in);
    chk_bits("open after precharge all", 8'h00, bank_open);
    cmd(LPBA_ACT, 3'h5, 15'h0030, 1'b0);
    repeat (4) @(posedge clock_in);
    chk_bits("open after reopen", 8'h20, bank_open);
  endtask : t_close
  initial begin
    rstn = 1'b0;
    dev_rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = LPBA_ACT;
    cmd_bank = 3'h0;
    cmd_addr = 15'h0000;
    cmd_all = 1'b0;
    wr_data = 128'h0;
    wr_mask = 16'h0000;
    err_seen = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (6) @(posedge clock_in);
    rstn <= 1'b1;
    // device reset runs on the link clock, which starts only now
    repeat (8) @(posedge clock_in);
    dev_rstn <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_open();
    t_data();
    t_close();
    chk_bits("closed bank access flag", 8'h00, {7'h00, err_seen});
    finish_test();
  end
endmodule : tb_lpddr3_bank_access_timing
`default_nettype wire
